// file: rtl/tbp_consts.vh
`ifndef TBP_CONSTS_VH
`define TBP_CONSTS_VH
// Register indices (byte address = index * 4 not used; plain port index)
`define TBP_ADDR_MODE_CTRL    3'h0
`define TBP_ADDR_WIDTH_HIGH   3'h1
`define TBP_ADDR_WIDTH_LOW    3'h2
`define TBP_ADDR_PRESC_LOW    3'h3
`define TBP_ADDR_PRESC_HIGH   3'h4
`define TBP_ADDR_FIRE_COUNT   3'h5
`define TBP_ADDR_IRQ_CONFIG   3'h6
`define TBP_ADDR_STATUS       3'h7
// Mode control fields
`define TBP_BIT_SENSE         0
`define TBP_BIT_MODE_LO       2
`define TBP_BIT_MODE_HI       3
`define TBP_BIT_CLK_SEL       4
`define TBP_BIT_RUN           5
`define TBP_BIT_MERGE         6
`define TBP_BIT_RELEASE       7
`define TBP_MODE_PWM          2'h0
`define TBP_MODE_BURST        2'h1
// Interrupt select field position
`define TBP_IRQ_SEL_LO        3
`define TBP_IRQ_SEL_HI        5
`define TBP_IRQ_NONE          3'h0
`define TBP_IRQ_RISE          3'h1
`define TBP_IRQ_FALL          3'h2
`define TBP_IRQ_BOTH          3'h3
`define TBP_IRQ_PULSE         3'h4
// Reset values
`define TBP_RST_MODE_CTRL     8'h00
`define TBP_RST_BYTE          8'h00
// Frame length in prescaled ticks
`define TBP_FRAME_TICKS       8'hff
// Pulses in a phase-angle train
`define TBP_TRAIN_PULSES      4'h8
`endif

// file: rtl/tbp_driver.v
`timescale 1ns/1ps
// Behaviour
// - Burst frame period is 255 ticks
// - Burst tick is mains divided by N+1
// - On-time is count ticks, pulses per crossing
// - New count applies next frame; N fixed
// - First pulse at first zero crossing
// - Pulses from sync A rise, sync B fall
// - Later positive-sense pulses centred on the crossing
// - Pulse width is clock times 16-bit width
// - Sense bit inverts output immediately
// - Negative quadrant pulses on both sync edges
// - Burst interrupt choice: none, edges, pulse
// - Zero width or count: no pulse, no pulse irq
// - Interrupt select field bits 5:3 only
// - Phase delay is count+1 times clock times N+1
// - Merge bit takes sync B from sync A
// - Phase mode emits eight 50% pulses
// - Phase interrupt choice: sync edges or pulse
// - Zero phase width: idle output, irq still
// - Control holds clock select, run, release
// - Mode field: PWM, burst, phase angle
// - Release low holds reset, output floating
`include "tbp_consts.vh"
module tbp_driver (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       clk_en,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       mains_sync_a,
  input  wire       mains_sync_b,
  output reg        firing_output,
  output reg        firing_output_oe,
  output reg        irq_event
);

  reg  [7:0]  triac_mode_control;
  reg  [7:0]  pulse_width_high;
  reg  [7:0]  pulse_width_low;
  reg  [7:0]  prescale_low;
  reg  [7:0]  prescale_high;
  reg  [7:0]  fire_count;
  reg  [7:0]  irq_config;
  reg  [2:0]  sa_sync;
  reg  [2:0]  sb_sync;
  reg         sa_level;
  reg         sb_level;
  reg  [15:0] presc_cnt;
  reg  [7:0]  frame_cnt;
  reg  [7:0]  frame_on;
  reg         burst_frame_wave;
  reg  [15:0] width_cnt;
  reg         pulse_on;
  reg         pending;
  reg         phase_wait;
  reg  [7:0]  phase_cnt;
  reg  [15:0] phase_presc;
  reg  [3:0]  train_cnt;
  reg         train_hi;
  reg         started;

  wire        running;
  wire [1:0]  mode;
  wire        is_burst;
  wire        is_phase;
  wire        sense;
  wire [15:0] gate_len_value;
  wire [15:0] presc_value;
  wire [15:0] half_width;
  wire [2:0]  irq_select;
  wire        sb_eff_level;
  wire        sa_rise;
  wire        sb_fall;
  wire        fire_ok;
  wire        sync_sample;
  wire        tick;
  wire        burst_zc;
  wire        burst_pre;
  wire        frame_end;
  wire        width_done;
  wire        pulse_irq;
  wire        frame_rise;
  wire        frame_fall;
  wire        first_train;
  reg         raw_fire;
  reg         next_irq;

  assign running        = triac_mode_control[`TBP_BIT_RELEASE] &
                          triac_mode_control[`TBP_BIT_RUN];
  assign mode           = triac_mode_control[`TBP_BIT_MODE_HI:`TBP_BIT_MODE_LO];
  assign is_burst       = (mode == `TBP_MODE_BURST);
  assign is_phase       = mode[1];
  assign sense          = triac_mode_control[`TBP_BIT_SENSE];
  assign gate_len_value = {pulse_width_high, pulse_width_low};
  assign presc_value    = {prescale_high, prescale_low};
  assign half_width     = {1'b0, gate_len_value[15:1]};
  assign irq_select     = irq_config[`TBP_IRQ_SEL_HI:`TBP_IRQ_SEL_LO];
  // Merge takes sync B from the already filtered sync A
  assign sb_eff_level   = triac_mode_control[`TBP_BIT_MERGE] ? sa_level : sb_level;
  assign sa_rise        = (sa_sync[2:1] == 2'b11) & ~sa_level;
  assign sync_sample    = (sb_sync[2:1] == 2'b00) & sb_level &
                          ~triac_mode_control[`TBP_BIT_MERGE];
  assign sb_fall        = triac_mode_control[`TBP_BIT_MERGE] ?
                          ((sa_sync[2:1] == 2'b00) & sa_level) : sync_sample;
  // A frame opens on the first crossing after start, one cycle before its wave
  // flop is set, so that crossing must be allowed to fire on its own
  assign fire_ok        = burst_frame_wave |
                          (~started & burst_zc & (fire_count != 8'h00));
  // Sync A rise marks pre-crossing, sync B fall post-crossing
  assign burst_pre      = sa_rise;
  assign burst_zc       = sb_fall;
  // One mains period per prescaler step from sync A rise
  // Ticks count only once the frame has been anchored to a crossing
  assign tick           = burst_pre & started & (presc_cnt == presc_value);
  assign frame_end      = tick & (frame_cnt == `TBP_FRAME_TICKS - 8'h01);
  assign width_done     = pulse_on & (width_cnt == 16'h0001);
  assign frame_rise     = frame_end & (fire_count != 8'h00);
  assign frame_fall     = tick & (frame_cnt + 8'h01 == frame_on) & frame_on != 8'h00;
  assign first_train    = phase_wait & (phase_cnt == 8'h00) & (phase_presc == 16'h0000);
  // Negative sense also fires on sync A rise, so every gate raises one event
  // Positive sense gives one centred gate per crossing, reported at the crossing
  assign pulse_irq      = fire_ok & (gate_len_value != 16'h0000) &
                          (burst_zc | (burst_pre & sense));

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      triac_mode_control <= `TBP_RST_MODE_CTRL;
      pulse_width_high   <= `TBP_RST_BYTE;
      pulse_width_low    <= `TBP_RST_BYTE;
      prescale_low       <= `TBP_RST_BYTE;
      prescale_high      <= `TBP_RST_BYTE;
      fire_count         <= `TBP_RST_BYTE;
      irq_config         <= `TBP_RST_BYTE;
      reg_rdata          <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr) begin
        case (reg_addr)
          `TBP_ADDR_MODE_CTRL:  triac_mode_control <= reg_wdata;
          `TBP_ADDR_WIDTH_HIGH: pulse_width_high   <= reg_wdata;
          `TBP_ADDR_WIDTH_LOW:  pulse_width_low    <= reg_wdata;
          `TBP_ADDR_PRESC_LOW:  prescale_low       <= reg_wdata;
          `TBP_ADDR_PRESC_HIGH: prescale_high      <= reg_wdata;
          `TBP_ADDR_FIRE_COUNT: fire_count         <= reg_wdata;
          `TBP_ADDR_IRQ_CONFIG: irq_config         <= reg_wdata;
          default: ;
        endcase
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `TBP_ADDR_MODE_CTRL:  reg_rdata <= triac_mode_control;
          `TBP_ADDR_WIDTH_HIGH: reg_rdata <= pulse_width_high;
          `TBP_ADDR_WIDTH_LOW:  reg_rdata <= pulse_width_low;
          `TBP_ADDR_PRESC_LOW:  reg_rdata <= prescale_low;
          `TBP_ADDR_PRESC_HIGH: reg_rdata <= prescale_high;
          `TBP_ADDR_FIRE_COUNT: reg_rdata <= fire_count;
          `TBP_ADDR_IRQ_CONFIG: reg_rdata <= irq_config;
          `TBP_ADDR_STATUS:     reg_rdata <= {4'h0, train_hi, phase_wait,
                                              pulse_on, burst_frame_wave};
          default:              reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Three-stage pin synchronisers; a level is accepted when stages two and three agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sa_sync  <= 3'h0;
      sb_sync  <= 3'h0;
      sa_level <= 1'b0;
      sb_level <= 1'b0;
    end else if (clk_en) begin
      sa_sync <= {sa_sync[1:0], mains_sync_a};
      sb_sync <= {sb_sync[1:0], mains_sync_b};
      if (sa_sync[2] == sa_sync[1]) begin
        sa_level <= sa_sync[2];
      end
      if (sb_sync[2] == sb_sync[1]) begin
        sb_level <= sb_sync[2];
      end
    end
  end

  always @* begin
    next_irq = 1'b0;
    if (is_burst) begin
      case (irq_select)
        `TBP_IRQ_RISE:  next_irq = frame_rise;
        `TBP_IRQ_FALL:  next_irq = frame_fall;
        `TBP_IRQ_BOTH:  next_irq = frame_rise | frame_fall;
        `TBP_IRQ_PULSE: next_irq = pulse_irq;
        default:        next_irq = 1'b0;
      endcase
    end else if (is_phase) begin
      case (irq_select)
        `TBP_IRQ_RISE:  next_irq = sa_rise;
        `TBP_IRQ_FALL:  next_irq = sb_fall;
        `TBP_IRQ_BOTH:  next_irq = sa_rise | sb_fall;
        `TBP_IRQ_PULSE: next_irq = first_train;
        default:        next_irq = 1'b0;
      endcase
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_cnt        <= 16'h0000;
      frame_cnt        <= 8'h00;
      frame_on         <= 8'h00;
      burst_frame_wave <= 1'b0;
      width_cnt        <= 16'h0000;
      pulse_on         <= 1'b0;
      pending          <= 1'b0;
      started          <= 1'b0;
      phase_wait       <= 1'b0;
      phase_cnt        <= 8'h00;
      phase_presc      <= 16'h0000;
      train_cnt        <= 4'h0;
      train_hi         <= 1'b0;
      irq_event        <= 1'b0;
    end else if (clk_en) begin
      if (!running) begin
        // Block release low holds the engine in reset
        presc_cnt        <= 16'h0000;
        frame_cnt        <= 8'h00;
        frame_on         <= fire_count;
        burst_frame_wave <= 1'b0;
        width_cnt        <= 16'h0000;
        pulse_on         <= 1'b0;
        pending          <= 1'b0;
        started          <= 1'b0;
        phase_wait       <= 1'b0;
        phase_cnt        <= 8'h00;
        phase_presc      <= 16'h0000;
        train_cnt        <= 4'h0;
        train_hi         <= 1'b0;
        irq_event        <= 1'b0;
      end else begin
        irq_event <= next_irq;
        if (is_burst) begin
          if (burst_pre && started) begin
            presc_cnt <= (presc_cnt == presc_value) ? 16'h0000 : presc_cnt + 16'h0001;
          end
          if (tick) begin
            if (frame_end) begin
              frame_cnt        <= 8'h00;
              frame_on         <= fire_count;
              burst_frame_wave <= (fire_count != 8'h00);
            end else begin
              frame_cnt <= frame_cnt + 8'h01;
              if (frame_cnt + 8'h01 == frame_on) begin
                burst_frame_wave <= 1'b0;
              end
            end
          end
          // Frame and prescaler restart from the first crossing, so the
          // on-time covers whole ticks measured from the first gate
          if (!started && burst_zc) begin
            started          <= 1'b1;
            burst_frame_wave <= (fire_count != 8'h00);
            frame_on         <= fire_count;
            presc_cnt        <= 16'h0000;
            frame_cnt        <= 8'h00;
          end
          // Pulse is due on every crossing inside the on-time
          if (fire_ok && gate_len_value != 16'h0000) begin
            if (!started && burst_zc) begin
              pulse_on  <= 1'b1;
              width_cnt <= gate_len_value;
            end else if (burst_pre && !sense) begin
              pending   <= 1'b1;
              width_cnt <= half_width;
            end else if (burst_pre && sense) begin
              pulse_on  <= 1'b1;
              width_cnt <= gate_len_value;
            end else if (burst_zc && sense) begin
              pulse_on  <= 1'b1;
              width_cnt <= gate_len_value;
            end
          end
          // Positive sense waits out the leading half width to centre the pulse
          if (pending) begin
            if (width_cnt <= 16'h0001 || burst_zc) begin
              pending   <= 1'b0;
              pulse_on  <= 1'b1;
              width_cnt <= gate_len_value;
            end else begin
              width_cnt <= width_cnt - 16'h0001;
            end
          end else if (pulse_on) begin
            if (width_done) begin
              pulse_on <= 1'b0;
            end else begin
              width_cnt <= width_cnt - 16'h0001;
            end
          end
        end else if (is_phase) begin
          if (sa_rise || sb_fall) begin
            phase_wait  <= 1'b1;
            phase_cnt   <= fire_count;
            phase_presc <= presc_value;
            train_cnt   <= 4'h0;
            train_hi    <= 1'b0;
          end else if (phase_wait) begin
            // Delay is count plus one steps of N+1 clocks
            if (phase_cnt == 8'h00 && phase_presc == 16'h0000) begin
              phase_wait <= 1'b0;
              train_cnt  <= `TBP_TRAIN_PULSES;
              train_hi   <= 1'b1;
              width_cnt  <= gate_len_value;
            end else if (phase_presc == 16'h0000) begin
              phase_cnt   <= phase_cnt - 8'h01;
              phase_presc <= presc_value;
            end else begin
              phase_presc <= phase_presc - 16'h0001;
            end
          end else if (train_cnt != 4'h0) begin
            // Equal high and low halves, each one full width long
            if (width_cnt <= 16'h0001) begin
              width_cnt <= gate_len_value;
              train_hi  <= ~train_hi;
              if (train_hi) begin
                train_cnt <= train_cnt - 4'h1;
              end
            end else begin
              width_cnt <= width_cnt - 16'h0001;
            end
          end
        end
      end
    end
  end

  always @* begin
    raw_fire = 1'b0;
    if (is_burst) begin
      raw_fire = pulse_on;
    end else if (is_phase) begin
      raw_fire = train_hi & (train_cnt != 4'h0) & (gate_len_value != 16'h0000);
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      firing_output    <= 1'b0;
      firing_output_oe <= 1'b0;
    end else if (clk_en) begin
      firing_output    <= raw_fire ^ sense;
      firing_output_oe <= triac_mode_control[`TBP_BIT_RELEASE];
    end
  end

endmodule

// file: tb/tbp_props.sv
`timescale 1ns/1ps
`include "tbp_consts.vh"
module tbp_props (
  input wire       clk,
  input wire       sys_rst,
  input wire       clk_en,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       firing_output,
  input wire       firing_output_oe,
  input wire       irq_event
);
  reg  [7:0]  sh [0:7];
  reg  [16:0] act_cnt;
  integer     k;
  wire [7:0]  ctrl = sh[0];
  wire        act  = firing_output ^ ctrl[0];
  wire        run  = ctrl[7] && ctrl[5];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (k = 0; k < 8; k = k + 1) begin
        sh[k] <= 8'h00;
      end
      act_cnt <= 17'h0;
    end else if (clk_en) begin
      if (reg_wr) begin
        sh[reg_addr] <= reg_wdata;
      end
      // Length of the current active stretch of the gate line
      act_cnt <= act ? act_cnt + 17'h1 : 17'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_ctrl_read;
    reg_rd && reg_addr == `TBP_ADDR_MODE_CTRL ##1 1'b1;
  endsequence
  sequence s_one_shot;
    irq_event ##1 !irq_event;
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  ctrl_read_a: assert property (s_ctrl_read |-> reg_rdata[7:2] == $past(ctrl[7:2]))
    else $error("control read mismatch");
  oe_release_a: assert property ($stable(ctrl[7]) |-> firing_output_oe == ctrl[7])
    else $error("output enable wrong");
  idle_level_a: assert property (ctrl[7] && !ctrl[5] && $stable(ctrl) |-> !act)
    else $error("idle level wrong");
  burst_quiet_a: assert property (run && $stable(ctrl) && ctrl[3:2] == `TBP_MODE_BURST
    && ({sh[1], sh[2]} == 16'h0 || sh[5] == 8'h00)
    |-> !act && !(irq_event && sh[6][5:3] == `TBP_IRQ_PULSE))
    else $error("burst fired with zero width or count");
  irq_shot_a: assert property (irq_event |-> s_one_shot)
    else $error("interrupt longer than one cycle");
  irq_none_a: assert property (sh[6][5:3] == `TBP_IRQ_NONE && $stable(sh[6]) |-> !irq_event)
    else $error("interrupt with none selected");
  gate_width_a: assert property ($fell(act) && run && $stable(ctrl)
    && ctrl[3:2] != `TBP_MODE_PWM |-> act_cnt == {1'b0, sh[1], sh[2]})
    else $error("gate pulse width wrong");
endmodule
bind tbp_driver tbp_props u_props (
  .clk(clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .firing_output(firing_output),
  .firing_output_oe(firing_output_oe),
  .irq_event(irq_event)
);

// file: tb/tbp_mains_model.sv
`timescale 1ns/1ps
module tbp_mains_model (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [7:0] period,
  input  wire [7:0] gap,
  input  wire       noise,
  output reg        sync_a,
  output reg        sync_b
);
  reg [7:0] ph;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph     <= 8'h00;
      sync_a <= 1'b0;
      sync_b <= 1'b1;
    end else begin
      ph     <= (ph + 8'h01 >= period) ? 8'h00 : ph + 8'h01;
      // Sync A rises ahead of the crossing, sync B falls after it
      sync_a <= {1'b0, ph} < {gap, 1'b0};
      // A free sync B pin carries unrelated traffic
      sync_b <= noise ? ~sync_b : !(ph >= gap && {1'b0, ph} < 9'd3 * {1'b0, gap});
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "tbp_consts.vh"
module testbench;
  reg         clk, sys_rst, reg_wr, reg_rd, m_noise, sense, cnt_on, act_q;
  reg  [2:0]  reg_addr;
  reg  [7:0]  reg_wdata, rd_val, m_period, m_gap;
  reg  [31:0] seed;
  wire [7:0]  reg_rdata;
  wire        sync_a, sync_b, firing_output, firing_output_oe, irq_event;
  integer     n_errors, total_checks, n_act, n_irq, i, w, c;
  wire        act = firing_output ^ sense;
  tbp_driver u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(1'b1),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .mains_sync_a(sync_a),
    .mains_sync_b(sync_b),
    .firing_output(firing_output),
    .firing_output_oe(firing_output_oe),
    .irq_event(irq_event)
  );
  tbp_mains_model u_mains (
    .clk(clk),
    .sys_rst(sys_rst),
    .period(m_period),
    .gap(m_gap),
    .noise(m_noise),
    .sync_a(sync_a),
    .sync_b(sync_b)
  );
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function integer irqs(input [2:0] sel, input integer per);
    irqs = (sel == 3'h0) ? 0 : (sel < 3'h3) ? per : 2 * per;
  endfunction
  task chk(input string what, input [31:0] lo, input [31:0] hi, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (^got === 1'bx || got < lo || got > hi) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      rd_val = reg_rdata;
    end
  endtask
  task setup(input [7:0] ctl, input [15:0] wid, input [15:0] pre, input [7:0] cnt,
             input [2:0] sel);
    begin
      wr(`TBP_ADDR_MODE_CTRL, 8'h00);
      wr(`TBP_ADDR_WIDTH_HIGH, wid[15:8]);
      wr(`TBP_ADDR_WIDTH_LOW, wid[7:0]);
      wr(`TBP_ADDR_PRESC_LOW, pre[7:0]);
      wr(`TBP_ADDR_PRESC_HIGH, pre[15:8]);
      wr(`TBP_ADDR_FIRE_COUNT, cnt);
      wr(`TBP_ADDR_IRQ_CONFIG, {2'b00, sel, 3'b000});
      sense = ctl[0];
      wr(`TBP_ADDR_MODE_CTRL, ctl & 8'hdf);
      wr(`TBP_ADDR_MODE_CTRL, ctl);
    end
  endtask
  task watch(input integer cycles);
    begin
      n_act = 0;
      n_irq = 0;
      cnt_on = 1'b1;
      repeat (cycles) @(posedge clk);
      cnt_on = 1'b0;
    end
  endtask
  task phase_run(input [7:0] ctl, input [15:0] wid, input [2:0] sel, input integer lo);
    begin
      seed = xs(seed);
      // Delay plus train stays inside the shorter crossing gap
      setup(ctl, wid, {15'h0, seed[0]}, {6'h0, seed[2:1]} + 8'h01, sel);
      @(posedge sync_a);
      repeat (130) @(posedge clk);
      watch(1500);
      chk("phase irqs", irqs(sel, 10), irqs(sel, 10), n_irq);
      chk("phase pulses", lo, (wid == 16'h0000) ? 0 : 160, n_act);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    act_q <= act;
    if (cnt_on && act && !act_q) n_act = n_act + 1;
    if (cnt_on && irq_event === 1'b1) n_irq = n_irq + 1;
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("[ERR] watchdog expected done seen hang");
    wrap_up;
  end
  initial begin
    {sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 13'h0};
    {m_period, m_gap, m_noise, sense, cnt_on, act_q} = {8'd60, 8'd8, 4'h0};
    {seed, n_errors, total_checks, n_act, n_irq} = {32'hadbf1414, 128'h0};
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[2:0]);
      chk("reset value", `TBP_RST_BYTE, `TBP_RST_BYTE, {24'h0, rd_val});
    end
    wr(`TBP_ADDR_STATUS, 8'hff);
    rd(`TBP_ADDR_STATUS);
    chk("status", 0, 0, {24'h0, rd_val});
    for (i = 1; i < 6; i = i + 1) begin
      seed = xs(seed);
      wr(i[2:0], seed[7:0]);
      rd(i[2:0]);
      chk("readback", seed[7:0], seed[7:0], {24'h0, rd_val});
    end
    wr(`TBP_ADDR_MODE_CTRL, 8'h81);
    rd(`TBP_ADDR_MODE_CTRL);
    chk("mode ctrl", 8'h81, 8'h81, {24'h0, rd_val});
    chk("oe on", 1, 1, {31'h0, firing_output_oe});
    chk("idle high", 1, 1, {31'h0, firing_output});
    wr(`TBP_ADDR_MODE_CTRL, 8'h00);
    rd(`TBP_ADDR_MODE_CTRL);
    chk("oe off", 0, 0, {31'h0, firing_output_oe});
    seed = xs(seed);
    w = 2 + seed[1:0];
    c = 1 + seed[6:4];
    // Negative sense: one gate on each sync A rise and sync B fall
    setup(8'hb5, w[15:0], 16'h0, c[7:0], `TBP_IRQ_PULSE);
    watch(2 * 255 * 60);
    chk("burst pulses", 4 * c - 1, 4 * c, n_act);
    chk("burst irqs", 4 * c - 1, 4 * c, n_irq);
    setup(8'hb4, 16'h0, 16'h0, c[7:0], `TBP_IRQ_PULSE);
    watch(7650);
    chk("zero width", 0, 0, n_act + n_irq);
    setup(8'hb5, w[15:0], 16'h0, 8'h00, `TBP_IRQ_PULSE);
    watch(7650);
    chk("zero count", 0, 0, n_act + n_irq);
    {m_period, m_gap} = {8'd150, 8'd50};
    for (i = 0; i < 5; i = i + 1) begin
      seed = xs(seed);
      phase_run(8'ha8 | {7'h0, seed[3]}, 16'h0001 + {15'h0, seed[4]}, i[2:0], 160);
    end
    m_noise = 1'b1;
    phase_run(8'he8, 16'h0001, `TBP_IRQ_PULSE, 160);
    m_noise = 1'b0;
    phase_run(8'ha8, 16'h0000, `TBP_IRQ_PULSE, 0);
    wrap_up;
  end
endmodule
